// [design/pwm_gen_top.sv]
//
// Summary of operation
// - Each generator runs only while its enable bit (A bit0, B bit1) is set.
// - Fixed-duty select clear: duty follows that generator's mixer output.
// - Fixed-duty select set (A bit4, B bit5): duty from programmed level.
// - Fixed level is 10-bit two's complement; 0x000 half, 0x200 zero duty.
// - Clock select 000/001/010 gives 6.144/12.288/24.576 MHz generator clock.
// - In the 44.1 kHz family these become 5.6448/11.2896/22.5792 MHz.
// - Faster generator clock gives more counts per cycle, finer duty.
// - Each generator has a four-input mixer with source select and volume.
// - Generator outputs are never offered back as mixer sources.
// - Each generator waveform can drive a general-purpose pin directly.
// - Enabling a mixer path fails if system clock cycles are insufficient.
// - A failed enable leaves all running paths undisturbed.
// - Per-path status bits report which mixer paths really became enabled.
//
`timescale 1ns/100ps
module pwm_gen_top
  import pwm_pkg::*;
#(
  parameter int N_SRC = 8,
  parameter int SMP_W = 24,
  parameter int DEPTH = 16
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  input  wire logic [15:0]            reg_addr,
  input  wire logic [15:0]            reg_wdata,
  output logic      [15:0]            reg_rdata,
  input  wire logic                   sample_tick,
  input  wire logic                   rate_is_44k1,
  input  wire logic [N_SRC*SMP_W-1:0] src_sample,
  output logic                        sample_ready,
  input  wire logic [1:0]             gpio_func,
  output logic      [1:0]             pwm_pin
);
  generate
    if (N_SRC < 1 || N_SRC > 255 || SMP_W < 12) begin : g_chk
      $error("pwm_gen_top: unsupported source count or width");
    end
  endgenerate

  // ******************************
  // Register file
  // ******************************
  logic [15:0]          ctrl_r;
  logic [LVL_W-1:0]     lvl_r    [2];
  logic [MIX_SRC_W-1:0] src_sel_r [2][4];
  logic [MIX_VOL_W-1:0] vol_r    [2][4];
  logic [7:0]           act_r;
  logic [15:0]          rdata_nxt;

  wire hit_ctrl  = reg_addr == CTRL_ADDR;
  wire hit_lvl_a = reg_addr == LVL_A_ADDR;
  wire hit_lvl_b = reg_addr == LVL_B_ADDR;
  wire hit_mix   = (reg_addr[15:5] == MIX_BASE[15:5]) && (reg_addr[1:0] == 2'b00);
  wire mix_g     = reg_addr[MIX_GEN_BIT];
  wire [1:0] mix_n = reg_addr[MIX_IN_LSB +: 2];
  wire [2:0] mix_idx = {mix_g, mix_n};

  wire [1:0] gen_en  = {ctrl_r[EN_B_BIT], ctrl_r[EN_A_BIT]};
  wire [1:0] gen_ovd = {ctrl_r[OVD_B_BIT], ctrl_r[OVD_A_BIT]};
  wire [2:0] clk_sel = ctrl_r[CLK_SEL_MSB:CLK_SEL_LSB];

  wire [MIX_SRC_W-1:0] wr_src = reg_wdata[MIX_SRC_W-1:0];
  wire [MIX_VOL_W-1:0] wr_vol = reg_wdata[MIX_VOL_LSB +: MIX_VOL_W];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RESET;
      lvl_r  <= '{LVL_RESET, LVL_RESET};
    end else if (reg_wr) begin
      if (hit_ctrl) begin
        ctrl_r <= reg_wdata & CTRL_MASK;
      end
      if (hit_lvl_a) begin
        lvl_r[0] <= reg_wdata[LVL_W-1:0];
      end
      if (hit_lvl_b) begin
        lvl_r[1] <= reg_wdata[LVL_W-1:0];
      end
    end
  end

  // ******************************
  // Mixer path enable and clock check
  // ******************************
  logic [PERIOD_W-1:0] cyc_cnt_r;
  logic [PERIOD_W-1:0] cyc_last_r;
  logic [3:0]          act_cnt;

  always_comb begin
    act_cnt = '0;
    for (int i = 0; i < 8; i++) begin
      act_cnt = act_cnt + 4'(act_r[i]);
    end
  end

  wire [PERIOD_W+3:0] cyc_need = (PERIOD_W+4)'(act_cnt + 4'd1) * (PERIOD_W+4)'(CYC_PER_PATH);
  wire clk_enough = {4'h0, cyc_last_r} >= cyc_need;
  wire mix_wr     = reg_wr && hit_mix;
  wire path_on    = act_r[mix_idx];
  wire act_new    = (wr_src != '0) && (path_on || clk_enough);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_cnt_r  <= '0;
      cyc_last_r <= '0;
    end else if (sample_tick) begin
      cyc_cnt_r  <= '0;
      cyc_last_r <= cyc_cnt_r;
    end else if (!(&cyc_cnt_r)) begin
      cyc_cnt_r  <= cyc_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act_r <= '0;
    end else if (mix_wr) begin
      act_r[mix_idx] <= act_new;
    end
  end

  genvar g;
  genvar n;
  generate
    for (g = 0; g < 2; g++) begin : g_mreg
      for (n = 0; n < 4; n++) begin : g_in
        always_ff @(posedge clk or negedge rst_n) begin
          if (!rst_n) begin
            src_sel_r[g][n] <= '0;
            vol_r[g][n]     <= VOL_RESET;
          end else if (mix_wr && mix_idx == 3'(g*4+n)) begin
            src_sel_r[g][n] <= (wr_src == '0 || act_new) ? wr_src : src_sel_r[g][n];
            vol_r[g][n]     <= wr_vol;
          end
        end
      end
    end
  endgenerate

  // ******************************
  // Register read
  // ******************************
  wire [15:0] mix_word = {act_r[mix_idx], vol_r[mix_g][mix_n], src_sel_r[mix_g][mix_n]};

  always_comb begin
    rdata_nxt = '0;
    if (hit_ctrl) begin
      rdata_nxt = ctrl_r;
    end else if (hit_lvl_a) begin
      rdata_nxt = {6'h00, lvl_r[0]};
    end else if (hit_lvl_b) begin
      rdata_nxt = {6'h00, lvl_r[1]};
    end else if (hit_mix) begin
      rdata_nxt = mix_word;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end
  end

  // ******************************
  // Mixers
  // ******************************
  function automatic logic signed [SMP_W-1:0] pick_src(
    input logic [N_SRC*SMP_W-1:0] bus,
    input logic [MIX_SRC_W-1:0]   sel
  );
    logic signed [SMP_W-1:0] s;
    s = '0;
    for (int k = 0; k < N_SRC; k++) begin
      if (sel == MIX_SRC_W'(k + 1)) begin
        s = bus[k*SMP_W +: SMP_W];
      end
    end
    return s;
  endfunction

  localparam int PW  = SMP_W + MIX_VOL_W + 1;
  localparam int SW  = PW + 2;
  localparam int SHR = VOL_SHIFT + SMP_W - LVL_W;

  logic signed [PW-1:0] term  [2][4];
  logic signed [SW-1:0] msum  [2];
  logic [LVL_W-1:0]     mlvl  [2];

  generate
    for (g = 0; g < 2; g++) begin : g_mix
      for (n = 0; n < 4; n++) begin : g_term
        wire signed [SMP_W-1:0] smp = pick_src(src_sample, src_sel_r[g][n]);
        wire signed [MIX_VOL_W:0] vs = {1'b0, vol_r[g][n]};
        assign term[g][n] = act_r[g*4+n] ? PW'(smp * vs) : '0;
      end
      assign msum[g] = SW'(term[g][0]) + SW'(term[g][1]) + SW'(term[g][2]) + SW'(term[g][3]);
      wire signed [SW-1:0] shr = msum[g] >>> SHR;
      wire hi = shr > SW'(511);
      wire lo = shr < -SW'(512);
      assign mlvl[g] = hi ? 10'h1ff : lo ? 10'h200 : shr[LVL_W-1:0];
    end
  endgenerate

  // ******************************
  // Sample buffer
  // ******************************
  sample_if #(.W(2*LVL_W)) fin ();
  sample_if #(.W(2*LVL_W)) fout ();

  assign fin.valid  = sample_tick;
  assign fin.data   = {mlvl[1], mlvl[0]};
  assign fout.ready = sample_tick && (gen_en != 2'b00);
  assign sample_ready = fin.ready;

  sample_fifo #(.W(2*LVL_W), .DEPTH(DEPTH)) u_fifo (
    .clk   (clk),
    .rst_n (rst_n),
    .wr    (fin),
    .rd    (fout)
  );

  logic [LVL_W-1:0] aud_lvl_r [2];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aud_lvl_r <= '{10'h000, 10'h000};
    end else if (fout.ready && fout.valid) begin
      aud_lvl_r[0] <= fout.data[LVL_W-1:0];
      aud_lvl_r[1] <= fout.data[2*LVL_W-1:LVL_W];
    end
  end

  // ******************************
  // Generator clock
  // ******************************
  function automatic logic [NCO_W-1:0] nco_inc(input logic [2:0] sel, input logic fam44);
    longint f;
    int     i;
    i = (sel == CLK_SEL_MID) ? 1 : (sel == CLK_SEL_HIGH) ? 2 : 0;
    f = fam44 ? F44_HZ[i] : F48_HZ[i];
    return NCO_W'((f << NCO_W) / SYS_CLK_HZ);
  endfunction

  logic [NCO_W-1:0] nco_r;
  logic             gen_tick_r;
  wire  [NCO_W:0]   nco_nxt = {1'b0, nco_r} + {1'b0, nco_inc(clk_sel, rate_is_44k1)};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nco_r      <= '0;
      gen_tick_r <= 1'b0;
    end else begin
      nco_r      <= nco_nxt[NCO_W-1:0];
      gen_tick_r <= nco_nxt[NCO_W];
    end
  end

  // ******************************
  // Generators and pins
  // ******************************
  logic [1:0] pwm_raw;

  generate
    for (g = 0; g < 2; g++) begin : g_gen
      wire [LVL_W-1:0] duty = gen_ovd[g] ? lvl_r[g] : aud_lvl_r[g];
      pwm_core u_core (
        .clk         (clk),
        .rst_n       (rst_n),
        .gen_tick    (gen_tick_r),
        .sample_tick (sample_tick),
        .enable      (gen_en[g]),
        .level       (duty),
        .pwm         (pwm_raw[g])
      );
    end
  endgenerate

  // Waveform goes only to pins, never back into the mixers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_pin <= 2'b00;
    end else begin
      pwm_pin <= pwm_raw & gpio_func & gen_en;
    end
  end
endmodule // pwm_gen_top

// [common/pwm_pkg.sv]
package pwm_pkg;
  // ******************************
  // Register map
  // ******************************
  localparam logic [15:0] CTRL_ADDR    = 16'hc000;
  localparam logic [15:0] LVL_A_ADDR   = 16'hc004;
  localparam logic [15:0] LVL_B_ADDR   = 16'hc008;
  localparam logic [15:0] MIX_BASE     = 16'h8080;
  localparam int          MIX_GEN_BIT  = 4;
  localparam int          MIX_IN_LSB   = 2;
  localparam int          EN_A_BIT     = 0;
  localparam int          EN_B_BIT     = 1;
  localparam int          OVD_A_BIT    = 4;
  localparam int          OVD_B_BIT    = 5;
  localparam int          CLK_SEL_LSB  = 8;
  localparam int          CLK_SEL_MSB  = 10;
  localparam logic [15:0] CTRL_RESET   = 16'h0000;
  localparam logic [15:0] CTRL_MASK    = 16'h0733;
  localparam int          LVL_W        = 10;
  localparam logic [9:0]  LVL_RESET    = 10'h100;
  localparam logic [9:0]  LVL_OFFSET   = 10'h200;
  localparam int          MIX_STS_BIT  = 15;
  localparam int          MIX_VOL_LSB  = 8;
  localparam int          MIX_VOL_W    = 7;
  localparam int          MIX_SRC_W    = 8;
  localparam logic [6:0]  VOL_RESET    = 7'h40;
  localparam int          VOL_SHIFT    = 6;
  // ******************************
  // Generator clock
  // ******************************
  localparam logic [2:0]  CLK_SEL_LOW  = 3'b000;
  localparam logic [2:0]  CLK_SEL_MID  = 3'b001;
  localparam logic [2:0]  CLK_SEL_HIGH = 3'b010;
  localparam longint      SYS_CLK_HZ   = 40_000_000;
  localparam int          NCO_W        = 24;
  localparam longint      F48_HZ [3]   = '{6_144_000, 12_288_000, 24_576_000};
  localparam longint      F44_HZ [3]   = '{5_644_800, 11_289_600, 22_579_200};
  localparam int          CYC_PER_PATH = 16;
  localparam int          PERIOD_W     = 16;
endpackage

// [common/sample_if.sv]
`timescale 1ns/100ps
interface sample_if #(parameter int W = 20);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// [design/sample_fifo.sv]
`timescale 1ns/100ps
module sample_fifo #(
  parameter int W     = 20,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  sample_if.snk    wr,
  sample_if.src    rd
);
  localparam int AW = $clog2(DEPTH);
  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
      $error("sample_fifo depth must be a power of two");
    end
  endgenerate

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic          ready_r;
  logic          valid_r;
  wire           push = wr.valid & ready_r;
  wire           pop  = rd.ready & valid_r;
  wire [AW:0]    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);

  assign wr.ready = ready_r;
  assign rd.valid = valid_r;
  assign rd.data  = mem[rp_r];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= wr.data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r    <= '0;
      rp_r    <= '0;
      cnt_r   <= '0;
      ready_r <= 1'b1;
      valid_r <= 1'b0;
    end else begin
      wp_r    <= wp_r + AW'(push);
      rp_r    <= rp_r + AW'(pop);
      cnt_r   <= cnt_nxt;
      ready_r <= cnt_nxt != (AW+1)'(DEPTH);
      valid_r <= cnt_nxt != '0;
    end
  end
endmodule // sample_fifo

// [design/pwm_core.sv]
`timescale 1ns/100ps
module pwm_core
  import pwm_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             gen_tick,
  input  wire logic             sample_tick,
  input  wire logic             enable,
  input  wire logic [LVL_W-1:0] level,
  output logic                  pwm
);
  logic [PERIOD_W-1:0] cnt_r;
  logic [PERIOD_W-1:0] thr_r;
  wire  [LVL_W:0]      duty = {1'b0, level ^ LVL_OFFSET};
  wire  [PERIOD_W+LVL_W:0] prod = cnt_r * duty;
  wire  [PERIOD_W-1:0] thr_nxt = prod[PERIOD_W+LVL_W-1:LVL_W];
  wire                 cnt_max = &cnt_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      thr_r <= '0;
      pwm   <= 1'b0;
    end else begin
      if (sample_tick) begin
        cnt_r <= '0;
        thr_r <= thr_nxt;
      end else if (gen_tick && !cnt_max) begin
        cnt_r <= cnt_r + 1'b1;
      end
      pwm <= enable && (cnt_r < thr_r);
    end
  end
endmodule // pwm_core

// [tb/pwm_gen_props.sv]
`timescale 1ns/100ps
module pwm_gen_props
  import pwm_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic [1:0]  gpio_func,
  input wire logic [1:0]  pwm_pin
);
  // ****
  // Shadow of control and level A
  // ****
  logic [15:0] ctrl_r;
  logic [9:0]  lvl_a_r;
  logic [8:0]  zero_r;
  wire         zero_a = ctrl_r[OVD_A_BIT] && lvl_a_r == LVL_OFFSET;
  wire         mapped = reg_addr inside {CTRL_ADDR, LVL_A_ADDR, LVL_B_ADDR} ||
                        (reg_addr[15:5] == MIX_BASE[15:5] && reg_addr[1:0] == 2'b00);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r  <= CTRL_RESET;
      lvl_a_r <= LVL_RESET;
    end else if (reg_wr && reg_addr == CTRL_ADDR) begin
      ctrl_r <= reg_wdata & CTRL_MASK;
    end else if (reg_wr && reg_addr == LVL_A_ADDR) begin
      lvl_a_r <= reg_wdata[9:0];
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n || !zero_a) zero_r <= 9'h000;
    else if (zero_r != 9'h1ff) zero_r <= zero_r + 9'h001;
  end
  // ****
  // Properties
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_read(logic [15:0] a);
    reg_rd && reg_addr == a;
  endsequence
  a_pin_off_a: assert property ((!ctrl_r[EN_A_BIT])[*2] |-> !pwm_pin[0])
    else $error("generator a pin active while disabled");
  a_pin_off_b: assert property ((!ctrl_r[EN_B_BIT])[*2] |-> !pwm_pin[1])
    else $error("generator b pin active while disabled");
  a_gpio_gate: assert property ((pwm_pin & ~gpio_func & ~$past(gpio_func)) == 2'b00)
    else $error("pin active without its pin function");
  a_zero_duty: assert property (zero_r > 9'h100 |-> !pwm_pin[0])
    else $error("zero duty level still drives pin high");
  a_ctrl_read: assert property (s_read(CTRL_ADDR) |=> reg_rdata == $past(ctrl_r))
    else $error("control readback wrong");
  a_level_read: assert property (s_read(LVL_A_ADDR) |=> reg_rdata == {6'h00, $past(lvl_a_r)})
    else $error("level readback wrong");
  a_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");
endmodule // pwm_gen_props
bind pwm_gen_top pwm_gen_props chk (
  .clk(clk),
  .rst_n(rst_n),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .gpio_func(gpio_func),
  .pwm_pin(pwm_pin)
);

// [tb/mixer_feed.sv]
`timescale 1ns/100ps
module mixer_feed #(
  parameter int N_SRC = 8,
  parameter int SMP_W = 24
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic [15:0]            period,
  input  wire logic [SMP_W-1:0]       value,
  output logic                        sample_tick,
  output logic      [N_SRC*SMP_W-1:0] src_sample
);
  // ****
  // One tick per sample, all sources share it
  // ****
  logic [15:0] cnt;
  initial begin
    sample_tick = 1'b0;
    src_sample  = '0;
  end
  always @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt         <= 16'h0000;
      sample_tick <= 1'b0;
    end else begin
      cnt         <= (cnt + 16'h0001 >= period) ? 16'h0000 : cnt + 16'h0001;
      sample_tick <= (cnt == 16'h0000);
      // Samples only valid at the tick
      src_sample  <= (cnt == 16'h0000) ? {N_SRC{value}} : ~{N_SRC{value}};
    end
  end
endmodule // mixer_feed

// [tb/pwm_gen_top_tb.sv]
`timescale 1ns/100ps
module pwm_gen_top_tb
  import pwm_pkg::*;
;
  logic         clk;
  logic         rst_n;
  logic         reg_wr;
  logic         reg_rd;
  logic [15:0]  reg_addr;
  logic [15:0]  reg_wdata;
  logic [15:0]  reg_rdata;
  logic         sample_tick;
  logic         rate_is_44k1;
  logic [191:0] src_sample;
  logic         sample_ready;
  logic [1:0]   gpio_func;
  logic [1:0]   pwm_pin;
  logic [15:0]  period;
  logic [23:0]  value;
  logic [9:0]   lv [3] = '{10'h200, 10'h000, 10'h1ff};
  logic [23:0]  smp [3] = '{24'h800000, 24'h000000, 24'h7fffff};
  int           pct [3] = '{0, 50, 100};
  int           fails;
  int           checks_done;
  pwm_gen_top dut (
    .clk(clk),
    .rst_n(rst_n),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .sample_tick(sample_tick),
    .rate_is_44k1(rate_is_44k1),
    .src_sample(src_sample),
    .sample_ready(sample_ready),
    .gpio_func(gpio_func),
    .pwm_pin(pwm_pin)
  );
  mixer_feed feed (
    .clk(clk),
    .rst_n(rst_n),
    .period(period),
    .value(value),
    .sample_tick(sample_tick),
    .src_sample(src_sample)
  );
  // ****
  // Tasks
  // ****
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(negedge clk);
    reg_rd   = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    chk(reg_rdata, exp);
  endtask
  // Share of pin high time in percent over four sample periods
  task automatic duty(input int g, input int p, input int warm);
    int hi;
    int n;
    hi = 0;
    n  = 4 * period;
    repeat (warm * period) @(negedge clk);
    repeat (n) begin
      @(negedge clk);
      hi += (pwm_pin[g] === 1'b1);
    end
    hi = hi * 100 / n;
    chk(16'((hi > p ? hi - p : p - hi) <= 12), 16'h0001);
  endtask
  task automatic results();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ****
  // Clock, watchdog, tests
  // ****
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #1500000;
    fails++;
    results();
  end
  initial begin
    rst_n        = 1'b0;
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    reg_addr     = 16'h0000;
    reg_wdata    = 16'h0000;
    rate_is_44k1 = 1'b0;
    gpio_func    = 2'b11;
    period       = 16'd160;
    value        = 24'h000000;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    rd(CTRL_ADDR, CTRL_RESET);
    rd(LVL_A_ADDR, 16'h0100);
    rd(LVL_B_ADDR, 16'h0100);
    rd(MIX_BASE, 16'h4000);
    chk({15'h0000, sample_ready}, 16'h0001);
    repeat (20 * 160) @(negedge clk);
    chk({15'h0000, sample_ready}, 16'h0000);
    wr(CTRL_ADDR, 16'hffff);
    rd(CTRL_ADDR, CTRL_MASK);
    wr(LVL_B_ADDR, 16'hffff);
    rd(LVL_B_ADDR, 16'h03ff);
    wr(16'hc00c, 16'hffff);
    rd(16'hc00c, 16'h0000);
    for (int c = 0; c < 3; c++) begin
      rate_is_44k1 = c[0];
      for (int i = 0; i < 3; i++) begin
        wr(LVL_A_ADDR, {6'h00, lv[i]});
        wr(LVL_B_ADDR, {6'h00, lv[i]});
        wr(CTRL_ADDR, 16'h0033 | (16'(c) << 8));
        duty(0, pct[i], 3);
        duty(1, pct[i], 0);
      end
    end
    wr(CTRL_ADDR, 16'h0230);
    duty(0, 0, 3);
    wr(CTRL_ADDR, 16'h0233);
    gpio_func = 2'b01;
    duty(1, 0, 2);
    gpio_func = 2'b11;
    wr(CTRL_ADDR, 16'h0203);
    wr(16'h8080, 16'h4001);
    wr(16'h8090, 16'h4001);
    rd(16'h8080, 16'hc001);
    rd(16'h8090, 16'hc001);
    for (int i = 0; i < 3; i++) begin
      value = smp[i];
      duty(0, pct[i], 20);
      duty(1, pct[i], 0);
    end
    // Sources off and settled before the sample rate changes
    wr(16'h8080, 16'h4000);
    wr(16'h8090, 16'h4000);
    repeat (5000) @(negedge clk);
    period = 16'd40;
    repeat (3 * 40) @(negedge clk);
    wr(16'h8080, 16'h4001);
    wr(16'h8090, 16'h4001);
    wr(16'h8084, 16'h2002);
    rd(16'h8084, 16'h2000);
    rd(16'h8080, 16'hc001);
    duty(0, 100, 20);
    results();
  end
endmodule // pwm_gen_top_tb
